// ===== hw/dng_gate.sv
// Noise gate on the stereo playback stream, between filter chain and DAC.
// Assumes samples arrive on clk with a one-cycle valid strobe, register port on clk.
`timescale 1ns/1ps
module dng_gate
    import dng_pkg::*;
#(
    parameter int unsigned MUTE_FAST_CYC   = DNG_MUTE_FAST_CYC,
    parameter int unsigned MUTE_SLOW_CYC   = DNG_MUTE_SLOW_CYC,
    parameter int unsigned UNMUTE_SLOW_CYC = DNG_UNMUTE_SLOW_CYC
)
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output      logic [7:0]  reg_rdata,
    input  wire logic        in_valid,
    input  wire dng_stereo_t in_data,
    output      logic        out_valid,
    output      dng_stereo_t out_data,
    output      logic        gate_muted
);

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [23:0] level_of(input logic [2:0] code);
        level_of = DNG_LEVEL_BASE << code;
    endfunction

    function automatic logic [23:0] mag_of(input logic [23:0] s);
        mag_of = s[23] ? 24'(~s + 24'h000001) : s;
    endfunction

    function automatic logic [23:0] attenuate(input logic [23:0] s, input logic [6:0] att);
        logic [6:0]         whole;
        logic [6:0]         part;
        logic [8:0]         q;
        logic signed [33:0] prod;
        whole = att / 7'h06;
        part  = att - 7'(whole * 7'h06);
        case (part)
            7'h00:   q = DNG_FRAC_Q8_0;
            7'h01:   q = DNG_FRAC_Q8_1;
            7'h02:   q = DNG_FRAC_Q8_2;
            7'h03:   q = DNG_FRAC_Q8_3;
            7'h04:   q = DNG_FRAC_Q8_4;
            default: q = DNG_FRAC_Q8_5;
        endcase
        prod = 34'($signed(s)) * 34'($signed({1'b0, q}));
        prod = prod >>> (whole + 7'h08);
        attenuate = (att >= DNG_MUTE_DB) ? 24'h000000 : prod[23:0];
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic       gate_on_r;
    logic [3:0] timing_r;
    logic [2:0] release_level_r;
    logic [2:0] engage_level_r;
    logic [7:0] rdata_r;

    wire logic hit_ctrl    = reg_addr == DNG_ADDR_CTRL;
    wire logic hit_timing  = reg_addr == DNG_ADDR_TIMING;
    wire logic hit_release = reg_addr == DNG_ADDR_RELEASE;
    wire logic hit_engage  = reg_addr == DNG_ADDR_ENGAGE;

    wire logic       silence_gate_on   = gate_on_r;
    wire logic       mute_fade_speed   = timing_r[DNG_BIT_MUTE_SPD];
    wire logic       unmute_fade_speed = timing_r[DNG_BIT_UNMUTE_SPD];
    wire logic [1:0] quiet_hold_length = timing_r[DNG_HOLD_LSB +: 2];

    // Reserved bits read as zero
    wire logic [7:0] rdata_nxt =
        hit_ctrl    ? {gate_on_r, 7'h00} :
        hit_timing  ? {4'h0, timing_r} :
        hit_release ? {5'h00, release_level_r} :
        hit_engage  ? {5'h00, engage_level_r} : 8'h00;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gate_on_r       <= DNG_RST_GATE_ON;
            timing_r        <= DNG_RST_TIMING;
            release_level_r <= DNG_RST_LEVEL;
            engage_level_r  <= DNG_RST_LEVEL;
            rdata_r         <= 8'h00;
        end
        else
        begin
            if (reg_wr && hit_ctrl)
                gate_on_r <= reg_wdata[DNG_BIT_GATE_ON];
            if (reg_wr && hit_timing)
                timing_r <= reg_wdata[3:0];
            if (reg_wr && hit_release)
                release_level_r <= reg_wdata[DNG_LEVEL_LSB +: 3];
            if (reg_wr && hit_engage)
                engage_level_r <= reg_wdata[DNG_LEVEL_LSB +: 3];
            if (reg_rd)
                rdata_r <= rdata_nxt;
        end
    end

    // ****************************************
    // Level detection
    // ****************************************
    wire logic [23:0] mag_l     = mag_of(in_data.left);
    wire logic [23:0] mag_r     = mag_of(in_data.right);
    wire logic [23:0] mag_max   = (mag_l > mag_r) ? mag_l : mag_r;
    wire logic [23:0] engage_lv = level_of(engage_level_r);
    wire logic [23:0] release_lv = level_of(release_level_r);
    wire logic        quiet     = in_valid && (mag_max < engage_lv);
    wire logic        loud      = in_valid && (mag_max >= engage_lv);
    wire logic        rel_hit   = in_valid && (mag_max > release_lv);

    wire logic [11:0] hold_len  = DNG_HOLD_BASE << quiet_hold_length;
    wire logic [10:0] hold_last = 11'(hold_len - 12'h001);

    // Both mute periods and the slow unmute exceed 4096 cycles, so they come in as parameters
    wire logic [20:0] dn_period = mute_fade_speed ? 21'(MUTE_SLOW_CYC)
                                                  : 21'(MUTE_FAST_CYC);
    wire logic [20:0] up_period = unmute_fade_speed ? 21'(DNG_UNMUTE_FAST_CYC)
                                                    : 21'(UNMUTE_SLOW_CYC);

    // ****************************************
    // Gate state machine
    // ****************************************
    dng_state_t  st_r;
    dng_state_t  st_nxt;
    logic [10:0] quiet_cnt_r;
    logic [10:0] quiet_cnt_nxt;
    logic [20:0] step_cnt_r;
    logic [20:0] step_cnt_nxt;
    logic [6:0]  att_r;
    logic [6:0]  att_nxt;

    wire logic [20:0] period   = (st_r == DNG_FADE_DN) ? dn_period : up_period;
    wire logic        step     = step_cnt_r >= 21'(period - 21'h000001);
    wire logic        fading   = (st_r == DNG_FADE_DN) || (st_r == DNG_FADE_UP);
    wire logic        hold_end = quiet && (quiet_cnt_r == hold_last);

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            DNG_OPEN:    if (hold_end) st_nxt = DNG_FADE_DN;
            DNG_FADE_DN: if (rel_hit) st_nxt = DNG_FADE_UP;
                         else if (step && att_r == 7'(DNG_MUTE_DB - 7'h01))
                             st_nxt = DNG_MUTED;
            DNG_MUTED:   if (rel_hit) st_nxt = DNG_FADE_UP;
            DNG_FADE_UP: if (att_r == 7'h00 || (step && att_r == 7'h01))
                             st_nxt = DNG_OPEN;
            default:     st_nxt = DNG_OPEN;
        endcase
        if (!silence_gate_on)
            st_nxt = DNG_OPEN;
    end

    always_comb
    begin
        quiet_cnt_nxt = quiet_cnt_r;
        if (!silence_gate_on || st_r != DNG_OPEN || loud || hold_end)
            quiet_cnt_nxt = 11'h000;
        else if (quiet)
            quiet_cnt_nxt = 11'(quiet_cnt_r + 11'h001);
    end

    // Step only while the state stays put, so a release never takes a stray dB
    always_comb
    begin
        att_nxt      = att_r;
        step_cnt_nxt = 21'h000000;
        if (!silence_gate_on)
            att_nxt = 7'h00;
        else if (fading && st_nxt == st_r)
        begin
            step_cnt_nxt = step ? 21'h000000 : 21'(step_cnt_r + 21'h000001);
            if (step && st_r == DNG_FADE_DN)
                att_nxt = 7'(att_r + 7'h01);
            else if (step && att_r != 7'h00)
                att_nxt = 7'(att_r - 7'h01);
        end
        else if (st_nxt == DNG_MUTED)
            att_nxt = DNG_MUTE_DB;
        else if (st_nxt == DNG_OPEN)
            att_nxt = 7'h00;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r        <= DNG_OPEN;
            quiet_cnt_r <= 11'h000;
            step_cnt_r  <= 21'h000000;
            att_r       <= 7'h00;
        end
        else
        begin
            st_r        <= st_nxt;
            quiet_cnt_r <= quiet_cnt_nxt;
            step_cnt_r  <= step_cnt_nxt;
            att_r       <= att_nxt;
        end
    end

    // ****************************************
    // Sample path
    // ****************************************
    logic        out_valid_r;
    dng_stereo_t out_data_r;
    logic        muted_r;

    wire dng_stereo_t gated = '{left:  attenuate(in_data.left, att_r),
                                right: attenuate(in_data.right, att_r)};
    wire dng_stereo_t out_nxt = silence_gate_on ? gated : in_data;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            out_valid_r <= 1'b0;
            out_data_r  <= '0;
            muted_r     <= 1'b0;
        end
        else
        begin
            out_valid_r <= in_valid;
            if (in_valid)
                out_data_r <= out_nxt;
            muted_r <= st_nxt == DNG_MUTED;
        end
    end

    assign reg_rdata  = rdata_r;
    assign out_valid  = out_valid_r;
    assign out_data   = out_data_r;
    assign gate_muted = muted_r;

    // ****************************************
    // Checks
    // ****************************************
    sequence seq_quiet_done;
        silence_gate_on && st_r == DNG_OPEN && quiet && quiet_cnt_r == hold_last;
    endsequence

    sequence seq_dn_step;
        st_r == DNG_FADE_DN && step && !rel_hit && att_r < 7'(DNG_MUTE_DB - 7'h01);
    endsequence

    AST_BYPASS: assert property (@(posedge clk) disable iff (sys_rst)
        (!silence_gate_on && in_valid) |=> out_valid && out_data == $past(in_data))
        else $error("Disabled gate altered a sample");

    AST_HOLD_DONE: assert property (@(posedge clk) disable iff (sys_rst)
        seq_quiet_done |=> st_r == DNG_FADE_DN && quiet_cnt_r == 11'h000)
        else $error("Hold end did not start the fade down");

    AST_ENGAGE_CAUSE: assert property (@(posedge clk) disable iff (sys_rst)
        (st_r == DNG_OPEN ##1 st_r == DNG_FADE_DN) |-> $past(mag_max) < $past(engage_lv))
        else $error("Fade down began on a loud sample");

    AST_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
        (silence_gate_on && st_r == DNG_MUTED && mag_max > release_lv && in_valid)
        |=> st_r == DNG_FADE_UP)
        else $error("Release level crossed but gate stayed muted");

    AST_DN_RATE: assert property (@(posedge clk) disable iff (sys_rst)
        silence_gate_on ##0 seq_dn_step
        |=> att_r == 7'($past(att_r) + 7'h01) && step_cnt_r == 21'h000000)
        else $error("Fade down step missing");

    AST_UP_RATE: assert property (@(posedge clk) disable iff (sys_rst)
        (silence_gate_on && st_r == DNG_FADE_UP && step && att_r > 7'h01 && st_nxt == st_r)
        |=> att_r == 7'($past(att_r) - 7'h01) && step_cnt_r == 21'h000000)
        else $error("Fade up step missing");

    AST_QUIET_RESTART: assert property (@(posedge clk) disable iff (sys_rst)
        (silence_gate_on && st_r == DNG_OPEN && loud) |=> quiet_cnt_r == 11'h000)
        else $error("Loud sample did not restart the quiet count");

    AST_MUTE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        (silence_gate_on && st_r == DNG_MUTED && !rel_hit) ##1 silence_gate_on
        |-> st_r == DNG_MUTED && gate_muted)
        else $error("Mute dropped without a release");

endmodule

// ===== pkg/dng_pkg.sv
// Shared constants and types for the playback noise gate.
// Assumes a 100 MHz system clock and 24-bit two's-complement stereo samples.
package dng_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] DNG_ADDR_CTRL    = 8'h9C;
    localparam logic [7:0] DNG_ADDR_TIMING  = 8'h9D;
    localparam logic [7:0] DNG_ADDR_RELEASE = 8'h9E;
    localparam logic [7:0] DNG_ADDR_ENGAGE  = 8'h9F;

    localparam int DNG_BIT_GATE_ON   = 7;
    localparam int DNG_BIT_MUTE_SPD  = 3;
    localparam int DNG_BIT_UNMUTE_SPD = 2;
    localparam int DNG_HOLD_LSB      = 0;
    localparam int DNG_LEVEL_LSB     = 0;

    localparam logic       DNG_RST_GATE_ON = 1'h0;
    localparam logic [3:0] DNG_RST_TIMING  = 4'h0;
    localparam logic [2:0] DNG_RST_LEVEL   = 3'h0;

    // ****************************************
    // Levels and timing
    // ****************************************
    // Code 0 (-102 dBFS) is about 2^6 of a 2^23 full scale; each 6 dB step is one bit
    localparam logic [23:0] DNG_LEVEL_BASE = 24'h000040;
    localparam logic [11:0] DNG_HOLD_BASE  = 12'h100;
    // Attenuation at which the output is held at zero
    localparam logic [6:0]  DNG_MUTE_DB    = 7'h6C;

    localparam int DNG_CLK_NS          = 10;
    localparam int DNG_MUTE_FAST_NS    = 880000;
    localparam int DNG_MUTE_SLOW_NS    = 14080000;
    localparam int DNG_UNMUTE_SLOW_NS  = 220000;
    localparam int DNG_UNMUTE_FAST_NS  = 13800;
    localparam int DNG_MUTE_FAST_CYC   = DNG_MUTE_FAST_NS / DNG_CLK_NS;
    localparam int DNG_MUTE_SLOW_CYC   = DNG_MUTE_SLOW_NS / DNG_CLK_NS;
    localparam int DNG_UNMUTE_SLOW_CYC = DNG_UNMUTE_SLOW_NS / DNG_CLK_NS;
    localparam int DNG_UNMUTE_FAST_CYC = DNG_UNMUTE_FAST_NS / DNG_CLK_NS;

    // Fraction of one 6 dB step, 1 dB per entry, Q8
    localparam logic [8:0] DNG_FRAC_Q8_0 = 9'h100;
    localparam logic [8:0] DNG_FRAC_Q8_1 = 9'h0E4;
    localparam logic [8:0] DNG_FRAC_Q8_2 = 9'h0CB;
    localparam logic [8:0] DNG_FRAC_Q8_3 = 9'h0B5;
    localparam logic [8:0] DNG_FRAC_Q8_4 = 9'h0A2;
    localparam logic [8:0] DNG_FRAC_Q8_5 = 9'h090;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } dng_stereo_t;

    typedef enum logic [3:0] {
        DNG_OPEN    = 4'h1,
        DNG_FADE_DN = 4'h2,
        DNG_MUTED   = 4'h4,
        DNG_FADE_UP = 4'h8
    } dng_state_t;

endpackage

// ===== tb/dng_dac_sink.sv
// Far-side stand-in: the DAC input that takes every gated sample.
// Assumes out_valid is a one-cycle pulse on clk and no back-pressure.
`timescale 1ns/1ps
module dng_dac_sink
    import dng_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        out_valid,
    input  wire dng_stereo_t out_data,
    output      int          rx_cnt,
    output      dng_stereo_t rx_last
);
    // ****************************************
    // Capture
    // ****************************************
    // Counting strobes exposes a valid held longer than one cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_cnt  <= 0;
            rx_last <= '0;
        end
        else if (out_valid)
        begin
            rx_cnt  <= rx_cnt + 1;
            rx_last <= out_data;
        end
    end
endmodule

// ===== tb/dng_gate_test.sv
// Self-checking bench for the playback noise gate.
// Assumes the DAC sink model; inputs change on the falling edge of clk.
`timescale 1ns/1ps
module dng_gate_test
    import dng_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    logic        reg_wr;
    logic        reg_rd;
    logic        in_valid;
    logic        out_valid;
    logic        gate_muted;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    dng_stereo_t in_data;
    dng_stereo_t out_data;
    dng_stereo_t rx_last;
    int          rx_cnt;
    int          error_cnt;
    int          tests_run;
    int          sent;
    int          n;

    // Short fade periods keep the run brief
    dng_gate #(.MUTE_FAST_CYC(8), .MUTE_SLOW_CYC(16), .UNMUTE_SLOW_CYC(4)) dng_gate_i (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_data(in_data),
        .out_valid(out_valid), .out_data(out_data), .gate_muted(gate_muted));
    dng_dac_sink dng_dac_sink_i (.clk(clk), .sys_rst(sys_rst), .out_valid(out_valid),
        .out_data(out_data), .rx_cnt(rx_cnt), .rx_last(rx_last));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Helpers
    // ****************************************
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(48'(reg_rdata), 48'(exp), "register");
    endtask

    // Right channel carries the negated value, so both magnitudes match
    task automatic smp(input logic [23:0] v, input logic [23:0] exp, input logic eq);
        logic [23:0] nv;
        logic [23:0] ne;
        nv = -v;
        ne = -exp;
        @(negedge clk);
        in_valid = 1'b1;
        in_data = {v, nv};
        sent++;
        @(negedge clk);
        in_valid = 1'b0;
        chk(48'(out_valid), 48'h1, "out strobe");
        chk(48'(out_data === {exp, ne}), 48'(eq), "sample");
    endtask

    task automatic wait_muted(input logic lvl, input int lim);
        n = 0;
        while (gate_muted !== lvl && n < lim)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic [7:0] adr [5] = '{8'h9C, 8'h9D, 8'h9E, 8'h9F, 8'h9B};
        logic [7:0] msk [5] = '{8'h80, 8'h0F, 8'h07, 8'h07, 8'h00};
        for (int i = 0; i < 5; i++)
        begin
            rd(adr[i], 8'h00);
            wr(adr[i], 8'hFF);
            rd(adr[i], msk[i]);
        end
        for (int i = 0; i < 4; i++)
            wr(adr[i], 8'h00);
    endtask

    task automatic t_bypass();
        wr(DNG_ADDR_ENGAGE, 8'h07);
        smp(24'h000005, 24'h000005, 1'b1);
        smp(24'h7FFFFF, 24'h7FFFFF, 1'b1);
    endtask

    task automatic t_hold();
        wr(DNG_ADDR_CTRL, 8'h80);
        wr(DNG_ADDR_TIMING, 8'h08);
        wr(DNG_ADDR_RELEASE, 8'h01);
        wr(DNG_ADDR_ENGAGE, 8'h00);
        repeat (255) smp(24'h00003F, 24'h00003F, 1'b1);
        smp(24'h000040, 24'h000040, 1'b1);
        repeat (255) smp(24'h00003F, 24'h00003F, 1'b1);
        repeat (200) @(negedge clk);
        chk(48'(gate_muted), 48'h0, "muted early");
        smp(24'h00003F, 24'h00003F, 1'b1);
        wait_muted(1'b1, 2500);
        chk(48'(gate_muted), 48'h1, "muted");
        // Slow rate is 16 cycles a dB over 108 dB
        chk(48'(n >= 1600 && n <= 1800), 48'h1, "fade length");
    endtask

    task automatic t_release();
        smp(24'h000080, 24'h000000, 1'b1);
        chk(48'(gate_muted), 48'h1, "hysteresis");
        smp(24'h000081, 24'h000000, 1'b1);
        wait_muted(1'b0, 5);
        chk(48'(gate_muted), 48'h0, "released");
        repeat (500) @(negedge clk);
        smp(24'h123456, 24'h123456, 1'b1);
    endtask

    // Fast unmute is 1380 cycles a dB, so only one dB is undone here
    task automatic t_fast_up();
        wr(DNG_ADDR_TIMING, 8'h04);
        repeat (256) smp(24'h00003F, 24'h00003F, 1'b1);
        repeat (8) @(negedge clk);
        smp(24'h100000, 24'h100000, 1'b0);
        repeat (1300) @(negedge clk);
        smp(24'h100000, 24'h100000, 1'b0);
        repeat (100) @(negedge clk);
        smp(24'h100000, 24'h100000, 1'b1);
    endtask

    task automatic t_disable();
        wr(DNG_ADDR_TIMING, 8'h00);
        wr(DNG_ADDR_ENGAGE, 8'h07);
        repeat (256) smp(24'h001FFF, 24'h001FFF, 1'b1);
        repeat (300) @(negedge clk);
        smp(24'h7FFFFF, 24'h7FFFFF, 1'b0);
        wr(DNG_ADDR_CTRL, 8'h00);
        chk(48'(gate_muted), 48'h0, "gate off");
        smp(24'h7FFFFF, 24'h7FFFFF, 1'b1);
    endtask

    // ****************************************
    // Run
    // ****************************************
    initial
    begin
        #400000;
        error_cnt++;
        $display("wrong value at %0t: watchdog expired", $time);
        summarize();
    end

    initial
    begin
        sys_rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        in_valid = 1'b0;
        in_data = '0;
        error_cnt = 0;
        tests_run = 0;
        sent = 0;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        t_regs();
        t_bypass();
        t_hold();
        t_release();
        t_fast_up();
        t_disable();
        repeat (2) @(negedge clk);
        chk(48'(rx_cnt), 48'(sent), "sink count");
        summarize();
    end
endmodule
